// File: hw/wcu_pkg.sv
// constants, types and helpers of the watchpoint comparator unit
// assumes one bus clock; processor access strobes come from the same clock
// Summary of operation
// - each of the two comparators has a 32-bit read/write reference register cleared at reset.
// - the ignore mask is a 5-bit field at the bottom of each mask register, higher bits read zero.
// - a nonzero mask x leaves address bits x-1 to 0 out of the comparison for every watch type.
// - the mask setting is limited to 24: a written value keeps its low 5 bits, and any 5-bit value above 24 is stored as 24.
// - a read-only hit flag at bit 24 of function register 0 is set by the selected access.
// - reading function register 0 returns the hit flag and then clears it.
// - a 4-bit action field selects disabled, fetch, data read or data write watching.
// - comparator 0 matches addresses or data values by a select bit, comparator 1 addresses only.
// - a 2-bit size field selects byte, halfword or word value matching.
// - with value matching on, a link field names the comparator whose address match qualifies it.
package wcu_pkg;

	// register byte offsets
	localparam logic [11:0] OFS_REF0 = 12'h020;
	localparam logic [11:0] OFS_MASK0 = 12'h024;
	localparam logic [11:0] OFS_FUNC0 = 12'h028;
	localparam logic [11:0] OFS_REF1 = 12'h030;
	localparam logic [11:0] OFS_MASK1 = 12'h034;
	localparam logic [11:0] OFS_FUNC1 = 12'h038;

	// field positions
	localparam int FLD_FN_LO = 0;
	localparam int FLD_VME = 8;
	localparam int FLD_VSIZE_LO = 10;
	localparam int FLD_LINK = 12;
	localparam int FLD_HIT = 24;

	// reset values and limits
	localparam logic [31:0] RST_REF = 32'h0000_0000;
	localparam logic [4:0] RST_MASK = 5'h00;
	localparam logic [3:0] RST_FN = 4'h0;
	localparam logic [4:0] MASK_MAX = 5'h18;

	// action codes
	localparam logic [3:0] FN_OFF = 4'h0;
	localparam logic [3:0] FN_FETCH = 4'h4;
	localparam logic [3:0] FN_READ = 4'h5;
	localparam logic [3:0] FN_WRITE = 4'h6;

	// value sizes
	localparam logic [1:0] VS_BYTE = 2'h0;
	localparam logic [1:0] VS_HALF = 2'h1;
	localparam logic [1:0] VS_WORD = 2'h2;

	// processor access kinds
	typedef enum logic [1:0]
	{
		ACC_FETCH = 2'h0,
		ACC_READ = 2'h1,
		ACC_WRITE = 2'h2
	} wcu_acc_t;

	// AHB transfer type bit that marks NONSEQ/SEQ
	localparam int HTRANS_ACTIVE = 1;

	// does an action code watch this access kind
	function automatic logic wcu_fn_hit(input logic [3:0] fn, input wcu_acc_t kind);
		logic r;
		r = 1'b0;
		unique case (fn)
			FN_FETCH: r = (kind == ACC_FETCH);
			FN_READ: r = (kind == ACC_READ);
			FN_WRITE: r = (kind == ACC_WRITE);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

endpackage

// File: hw/wcu_cmp.sv
// one address comparator with its ignore mask
// assumes the mask is already limited to the legal range
`timescale 1ns/1ns
module wcu_cmp
(
	input wire logic [31:0] ref_value,
	input wire logic [4:0] mask_sel,
	input wire logic fetch_watch,
	input wire logic [31:0] addr,
	output logic addr_hit
);
	import wcu_pkg::*;

	logic [31:0] keep;

	////////////////////////////////////////////////////////////////
	// build the compare mask
	always_comb
	begin
		keep = 32'hFFFF_FFFF << mask_sel;
		if (mask_sel == 5'h00 && fetch_watch)
		begin
			keep[0] = 1'b0;
		end
	end

	assign addr_hit = ((addr ^ ref_value) & keep) == 32'h0000_0000;

endmodule

// File: hw/wcu_top.sv
// watchpoint comparator unit: two comparators, AHB-Lite register slave
// assumes processor access strobes and the bus share hclk; no synchroniser needed
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ns
module wcu_top
#(
	parameter int ADDR_W = 12
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic acc_valid,
	input wire wcu_pkg::wcu_acc_t acc_kind,
	input wire logic [31:0] acc_addr,
	input wire logic [31:0] acc_data,
	output logic hit0,
	output logic hit1
);
	import wcu_pkg::*;

	////////////////////////////////////////////////////////////////
	// parameter check: offsets need 12 address bits
	generate
		if (ADDR_W < 12)
		begin : g_bad_aw
			$error("wcu_top: ADDR_W below 12");
		end
	endgenerate

	typedef struct packed
	{
		logic [1:0][31:0] ref_val;
		logic [1:0][4:0] mask;
		logic [1:0][3:0] fn;
		logic vme;
		logic [1:0] vsize;
		logic link;
		logic [1:0] hit;
		logic wr_pend;
		logic rd_pend;
		logic [11:0] ph_addr;
		logic [31:0] rdata;
	} wcu_state_t;

	wcu_state_t st_ff;
	wcu_state_t nxt_st;
	logic [1:0] addr_hit;
	logic value_hit;
	logic [1:0] cmp_event;
	logic take;
	logic [11:0] cur_addr;

	// limit a written mask setting; both mask registers share this decode
	function automatic logic [4:0] clamp_mask(input logic [4:0] m);
		return (m > MASK_MAX) ? MASK_MAX : m;
	endfunction

	////////////////////////////////////////////////////////////////
	// address comparators
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_cmp
			wcu_cmp u_cmp
			(
				.ref_value(st_ff.ref_val[i]),
				.mask_sel(st_ff.mask[i]),
				.fetch_watch(st_ff.fn[i] == FN_FETCH),
				.addr(acc_addr),
				.addr_hit(addr_hit[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// data value compare on the lanes the access uses
	always_comb
	begin
		value_hit = 1'b0;
		unique case (st_ff.vsize)
			VS_BYTE:
				value_hit = acc_data[8*acc_addr[1:0] +: 8] == st_ff.ref_val[0][8*acc_addr[1:0] +: 8];
			VS_HALF:
				value_hit = acc_data[16*acc_addr[1] +: 16] == st_ff.ref_val[0][16*acc_addr[1] +: 16];
			VS_WORD:
				value_hit = acc_data == st_ff.ref_val[0];
			default:
				value_hit = 1'b0; // size 11 never matches
		endcase
	end

	////////////////////////////////////////////////////////////////
	// match events per comparator
	always_comb
	begin
		// address or value on comparator 0
		if (st_ff.vme)
		begin
			cmp_event[0] = value_hit & addr_hit[st_ff.link];
		end
		else
		begin
			cmp_event[0] = addr_hit[0];
		end
		cmp_event[1] = addr_hit[1];
		for (int i = 0; i < 2; i++)
		begin
			cmp_event[i] = cmp_event[i] & acc_valid & wcu_fn_hit(st_ff.fn[i], acc_kind);
		end
	end

	////////////////////////////////////////////////////////////////
	// bus address phase
	assign take = hsel & hready & htrans[HTRANS_ACTIVE];
	assign cur_addr = {haddr[11:2], 2'b00};

	// reads take one wait state so a write just before is visible
	assign hreadyout = ~st_ff.rd_pend;
	assign hresp = 1'b0;
	assign hrdata = st_ff.rdata;
	assign hit0 = st_ff.hit[0];
	assign hit1 = st_ff.hit[1];

	////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		nxt_st = st_ff;
		// write data phase commits
		if (st_ff.wr_pend)
		begin
			unique case (st_ff.ph_addr)
				OFS_REF0: nxt_st.ref_val[0] = hwdata;
				OFS_REF1: nxt_st.ref_val[1] = hwdata;
				OFS_MASK0: nxt_st.mask[0] = clamp_mask(hwdata[4:0]);
				OFS_MASK1: nxt_st.mask[1] = clamp_mask(hwdata[4:0]);
				OFS_FUNC0:
				begin
					nxt_st.fn[0] = hwdata[FLD_FN_LO +: 4];
					nxt_st.vme = hwdata[FLD_VME];
					nxt_st.vsize = hwdata[FLD_VSIZE_LO +: 2];
					nxt_st.link = hwdata[FLD_LINK];
				end
				OFS_FUNC1: nxt_st.fn[1] = hwdata[FLD_FN_LO +: 4];
				default: ; // unmapped writes are ignored
			endcase
		end
		// read wait cycle: load data, clear flag by read
		if (st_ff.rd_pend)
		begin
			nxt_st.rdata = 32'h0000_0000;
			unique case (st_ff.ph_addr)
				OFS_REF0: nxt_st.rdata = st_ff.ref_val[0];
				OFS_REF1: nxt_st.rdata = st_ff.ref_val[1];
				OFS_MASK0: nxt_st.rdata[4:0] = st_ff.mask[0];
				OFS_MASK1: nxt_st.rdata[4:0] = st_ff.mask[1];
				OFS_FUNC0:
				begin
					nxt_st.rdata[FLD_FN_LO +: 4] = st_ff.fn[0];
					nxt_st.rdata[FLD_VME] = st_ff.vme;
					nxt_st.rdata[FLD_VSIZE_LO +: 2] = st_ff.vsize;
					nxt_st.rdata[FLD_LINK] = st_ff.link;
					nxt_st.rdata[FLD_HIT] = st_ff.hit[0];
					nxt_st.hit[0] = 1'b0;
				end
				OFS_FUNC1:
				begin
					nxt_st.rdata[FLD_FN_LO +: 4] = st_ff.fn[1];
					nxt_st.rdata[FLD_HIT] = st_ff.hit[1];
					nxt_st.hit[1] = 1'b0;
				end
				default: ; // unmapped reads return zero
			endcase
		end
		for (int i = 0; i < 2; i++)
		begin
			if (cmp_event[i])
			begin
				nxt_st.hit[i] = 1'b1;
			end
		end
		// address phase capture; a read stalls, so no new take while pending
		nxt_st.wr_pend = take & hwrite;
		nxt_st.rd_pend = take & ~hwrite;
		if (take)
		begin
			nxt_st.ph_addr = cur_addr;
		end
	end

	////////////////////////////////////////////////////////////////
	// state register, frozen while clk_en is low
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_ff.ref_val <= {RST_REF, RST_REF};
			st_ff.mask <= {RST_MASK, RST_MASK};
			st_ff.fn <= {RST_FN, RST_FN};
			st_ff.vme <= 1'b0;
			st_ff.vsize <= VS_BYTE;
			st_ff.link <= 1'b0;
			st_ff.hit <= 2'b00;
			st_ff.wr_pend <= 1'b0;
			st_ff.rd_pend <= 1'b0;
			st_ff.ph_addr <= 12'h000;
			st_ff.rdata <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			st_ff <= nxt_st;
		end
	end

endmodule

// File: verification/wcu_top_props.sv
// assertions on the ports of the watchpoint comparator unit
// assumes clk_en high and hready tied back to hreadyout
`timescale 1ns/1ns
module wcu_top_props
	import wcu_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic acc_valid,
	input wire wcu_pkg::wcu_acc_t acc_kind,
	input wire logic hit0,
	input wire logic hit1
);
	logic [11:0] ra_ff;
	////////////////////////////////////////////////////////////////
	// last read address; data phase blocks the next one
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			ra_ff <= 12'h000;
		else if (hsel && hready && htrans[1] && !hwrite)
			ra_ff <= haddr[11:0];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_okay; hresp == 1'b0; endproperty
	property p_wait; !hreadyout |=> hreadyout; endproperty
	property p_fall; $fell(hit0) |-> $past(!hreadyout) && ra_ff == OFS_FUNC0; endproperty
	property p_rise; $rose(hit0) || $rose(hit1) |-> $past(acc_valid); endproperty
	property p_fn0; $rose(hreadyout) && ra_ff == OFS_FUNC0 |-> hrdata[24] == $past(hit0);
	endproperty
	property p_mask; $rose(hreadyout) && (ra_ff == OFS_MASK0 || ra_ff == OFS_MASK1)
		|-> hrdata[31:5] == 27'h0 && hrdata[4:0] <= MASK_MAX; endproperty
	property p_fn1; $rose(hreadyout) && ra_ff == OFS_FUNC1 |-> hrdata[23:4] == 20'h0;
	endproperty
	property p_kind; acc_valid && acc_kind == wcu_acc_t'(2'h3) && !hit0 |=> !hit0; endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	a_wait: assert property (p_wait) else $error("read wait too long");
	a_fall: assert property (p_fall) else $error("hit dropped without read");
	a_rise: assert property (p_rise) else $error("hit without access");
	a_fn0: assert property (p_fn0) else $error("hit bit read wrong");
	a_mask: assert property (p_mask) else $error("mask read wrong");
	a_fn1: assert property (p_fn1) else $error("function 1 bits not zero");
	a_kind: assert property (p_kind) else $error("unknown kind hit");
	c_clear: cover property (hit0 ##1 !hit0);
	c_hit1: cover property (hit1);
	c_fn0: cover property ($rose(hreadyout) && ra_ff == OFS_FUNC0);
endmodule
bind wcu_top wcu_top_props #(.ADDR_W(ADDR_W)) i_wcu_top_props (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .acc_valid(acc_valid),
	.acc_kind(acc_kind), .hit0(hit0), .hit1(hit1));

// File: verification/wcu_cpu_model.sv
// processor access model: one-cycle access pulses
// assumes the caller starts just after a rising edge
`timescale 1ns/1ns
module wcu_cpu_model
(
	input wire logic hclk,
	output logic acc_valid,
	output wcu_pkg::wcu_acc_t acc_kind,
	output logic [31:0] acc_addr,
	output logic [31:0] acc_data
);
	import wcu_pkg::*;
	initial
	begin
		acc_valid = 1'b0;
		acc_kind = ACC_FETCH;
		acc_addr = 32'h0;
		acc_data = 32'h0;
	end
	// idle lines show the inverse so stale values never match
	task automatic access(input wcu_acc_t k, input logic [31:0] a, input logic [31:0] d);
		acc_valid <= 1'b1;
		acc_kind <= k;
		acc_addr <= a;
		acc_data <= d;
		@(posedge hclk);
		acc_valid <= 1'b0;
		acc_addr <= ~a;
		acc_data <= ~d;
	endtask
endmodule

// File: verification/test_watchpoint_comparator_unit.sv
// self-checking bench of the watchpoint unit
// assumes the processor model and the checker bound to wcu_top
`timescale 1ns/1ns
module test_watchpoint_comparator_unit;
	import wcu_pkg::*;
	logic hclk, hresetn, hsel, hwrite, rdy, hreadyout, hresp, acc_valid, hit0, hit1;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, acc_addr, acc_data;
	wcu_acc_t acc_kind;
	int n_fail, compares, cycles;
	wcu_top i_wcu_top (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr),
		.acc_data(acc_data), .hit0(hit0), .hit1(hit1));
	wcu_cpu_model i_wcu_cpu_model (.hclk(hclk), .acc_valid(acc_valid), .acc_kind(acc_kind),
		.acc_addr(acc_addr), .acc_data(acc_data));
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// settled copy of hready, read at the next rising edge
	always @(negedge hclk) rdy = hreadyout;
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("%0d compares, %0d mismatches", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (rdy !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(q, e);
	endtask
	// one access, flags compared the cycle after, then both cleared by reads
	task automatic touch(input wcu_acc_t k, input logic [31:0] a, input logic [31:0] d,
		input logic e0, input logic e1);
		logic [31:0] q;
		i_wcu_cpu_model.access(k, a, d);
		@(negedge hclk);
		chk(32'({hit1, hit0}), 32'({e1, e0}));
		@(posedge hclk);
		bus(OFS_FUNC0, 1'b0, 32'h0, q);
		bus(OFS_FUNC1, 1'b0, 32'h0, q);
		chk(32'({hit1, hit0}), 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rdc(OFS_REF0, 32'h0);
		rdc(OFS_MASK1, 32'h0);
		wr(OFS_REF1, 32'hA5C3_0F81);
		rdc(OFS_REF1, 32'hA5C3_0F81);
		wr(OFS_MASK0, 32'hFFFF_FFE7);
		rdc(OFS_MASK0, 32'h7);
		wr(OFS_MASK0, 32'h19);
		rdc(OFS_MASK0, 32'h18);
		wr(OFS_MASK0, 32'h17);
		rdc(OFS_MASK0, 32'h17);
		rdc(12'h100, 32'h0);
		$display("t_regs finished");
	endtask
	task automatic t_mask();
		wr(OFS_REF0, 32'h1000);
		wr(OFS_MASK0, 32'h4);
		wr(OFS_FUNC0, 32'h5);
		touch(ACC_READ, 32'h100F, 32'h0, 1'b1, 1'b0);
		touch(ACC_READ, 32'h1010, 32'h0, 1'b0, 1'b0);
		touch(ACC_WRITE, 32'h1000, 32'h0, 1'b0, 1'b0);
		touch(wcu_acc_t'(2'h3), 32'h1000, 32'h0, 1'b0, 1'b0);
		i_wcu_cpu_model.access(ACC_READ, 32'h1004, 32'h0);
		repeat (3) @(posedge hclk);
		rdc(OFS_FUNC0, 32'h0100_0005);
		rdc(OFS_FUNC0, 32'h5);
		wr(OFS_MASK0, 32'h0);
		wr(OFS_FUNC0, 32'h4);
		touch(ACC_FETCH, 32'h1001, 32'h0, 1'b1, 1'b0);
		wr(OFS_FUNC0, 32'h5);
		touch(ACC_READ, 32'h1001, 32'h0, 1'b0, 1'b0);
		wr(OFS_FUNC0, 32'h0);
		touch(ACC_READ, 32'h1000, 32'h0, 1'b0, 1'b0);
		// unsupported action code with a matching address
		wr(OFS_FUNC0, 32'h7);
		touch(ACC_READ, 32'h1000, 32'h0, 1'b0, 1'b0);
		$display("t_mask finished");
	endtask
	task automatic t_value();
		wr(OFS_REF1, 32'h3000);
		wr(OFS_MASK1, 32'h2);
		// byte value replicated into every lane
		wr(OFS_REF0, 32'h5A5A_5A5A);
		for (int s = 0; s < 3; s++)
		begin
			wr(OFS_FUNC0, 32'h1106 | (s << 10));
			touch(ACC_WRITE, 32'h3002, 32'h5A5A_5A5A, 1'b1, 1'b0);
			touch(ACC_WRITE, 32'h3002, 32'h5A5B_5B5A, 1'b0, 1'b0);
		end
		touch(ACC_WRITE, 32'h3004, 32'h5A5A_5A5A, 1'b0, 1'b0);
		// size code 11 never matches, even with lanes and link agreeing
		wr(OFS_FUNC0, 32'h1D06);
		touch(ACC_WRITE, 32'h3002, 32'h5A5A_5A5A, 1'b0, 1'b0);
		$display("t_value finished");
	endtask
	task automatic t_fn1();
		wr(OFS_FUNC1, 32'h1D06);
		rdc(OFS_FUNC1, 32'h6);
		touch(ACC_WRITE, 32'h3001, 32'h0, 1'b0, 1'b1);
		$display("t_fn1 finished");
	endtask
	initial
	begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
		{n_fail, compares, cycles} = '0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_mask();
		t_value();
		t_fn1();
		end_of_test();
	end
endmodule
